// >>> rtl/interrupt_enable_bank.sv
/*
  Interrupt enable bank: five enable registers, the matching flag
  registers and per-source priority fields, reached over APB; forwards
  each qualified request to the processor dispatch logic.
  Assumes one clock, request inputs from logic on the same clock, and an
  APB master that keeps the protocol.
*/
// What this block does
// [RULE1] an enable bit of one passes its source's request, zero blocks it
// [RULE2] unimplemented enable bit positions read zero and ignore writes
// [RULE3] implemented enable bits are read/write and clear to zero at reset
// [RULE4] without the CAN controller its three enable bits have no effect
// [RULE5] without the audio converter its two channel enables have no effect
// [RULE6] first register: bit 2 compare ch1, bit 1 capture ch1, bit 0 ext irq 0
// [RULE7] second register bits 15..8: uart2 tx/rx, ext2, timers, compare 4/3, dma2
// [RULE8] second register: bits 7,6 capture 8,7; bit 5 unused; bits 4..0 others
// [RULE9] third register: bits 14,13 and 4..0 used; bits 12..5 unused
// [RULE10] fourth register: bits 15..13 and 10..9 used, all others unused
// [RULE11] fifth register: bits 15,14 converter, 11..9 used; 13..12, 8..7 unused
// [RULE12] fifth register: bits 6..1 can tx, dma7, dma6, crc, uart errors
// [RULE13] each source has a flag at the same position, set by its request
// [RULE14] each source has a 3-bit priority; zero disables the source
// [RULE15] forward only when flag, enable and non-zero priority all hold
`timescale 1ns/1ns
`default_nettype none

`include "irq_enable_defines.svh"

module interrupt_enable_bank
  import irq_enable_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_DAC = 1'b1
)
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`IEB_ADDR_W-1:0] PADDR_I,
  input wire logic [`IEB_DATA_W-1:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire irq_bank_t SRC_REQ_I,
  output var logic [`IEB_DATA_W-1:0] PRDATA_O,
  output var logic PREADY_O,
  output var logic PSLVERR_O,
  output var irq_bank_t IRQ_REQ_O
);

  // implemented positions per register
  function automatic word_t impl_mask(input logic [`IEB_IDX_W-1:0] k);
    word_t m;
    m = '0;
    case (k)
      3'h0: m = `IEB_IMPL0; // [RULE6]
      3'h1: m = `IEB_IMPL1; // [RULE7] [RULE8]
      3'h2: m = `IEB_IMPL2; // [RULE9]
      3'h3: m = `IEB_IMPL3; // [RULE10]
      3'h4: m = `IEB_IMPL4; // [RULE11] [RULE12]
      default: m = '0;
    endcase
    return m;
  endfunction

  // bits that the build variant leaves dead
  function automatic word_t variant_mask(input logic [`IEB_IDX_W-1:0] k);
    word_t m;
    m = '1;
    if (!HAS_CAN && k == 3'h2)
    begin
      m = m & ~`IEB_CAN_BITS2; // [RULE4]
    end
    if (!HAS_CAN && k == 3'h4)
    begin
      m = m & ~`IEB_CAN_BITS4; // [RULE4]
    end
    if (!HAS_DAC && k == 3'h4)
    begin
      m = m & ~`IEB_DAC_BITS4; // [RULE5]
    end
    return m;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic word_t merge16(input word_t old, input word_t wd, input logic [1:0] strb);
    word_t r;
    r = old;
    if (strb[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // address decode; misaligned or unlisted addresses decode to none
  function automatic dec_t decode(input logic [`IEB_ADDR_W-1:0] a);
    dec_t d;
    logic [`IEB_ADDR_W-1:0] off;
    d.kind = DEC_NONE;
    d.idx = '0;
    off = '0;
    if (a[1:0] == 2'h0)
    begin
      if (a <= `IEB_EN_LAST)
      begin
        off = a - `IEB_EN_BASE;
        d.kind = DEC_EN;
        d.idx = off[4:2];
      end
      else if (a >= `IEB_FLAG_BASE && a <= `IEB_FLAG_LAST)
      begin
        off = a - `IEB_FLAG_BASE;
        d.kind = DEC_FLAG;
        d.idx = off[4:2];
      end
      else if (a >= `IEB_PRIO_BASE && a <= `IEB_PRIO_LAST)
      begin
        off = a - `IEB_PRIO_BASE;
        d.kind = off[2] ? DEC_PRIO_HI : DEC_PRIO_LO;
        d.idx = off[5:3];
      end
    end
    return d;
  endfunction

  irq_bank_t en_q;
  irq_bank_t flag_q;
  irq_bank_t flag_d;
  irq_bank_t req_q;
  irq_bank_t live_mask;
  irq_bank_t prio_nz;
  prio_t prio_q [`IEB_NUM_REGS][`IEB_REG_W];
  logic pready_q;
  logic pslverr_q;
  logic [`IEB_DATA_W-1:0] prdata_q;
  logic [`IEB_DATA_W-1:0] rdata_d;
  dec_t dec;
  logic access;
  logic first_access;
  logic wr_done;
  word_t rd_impl;

  // bus phase decode
  assign dec = decode(PADDR_I);
  assign access = PSEL_I & PENABLE_I;
  assign first_access = access & ~pready_q;
  assign wr_done = access & pready_q & PWRITE_I;
  // a function result cannot be bit-selected, so the mask gets a net of its own
  assign rd_impl = impl_mask(dec.idx);

  // per-bit qualifiers of the request path; reads do not use them
  always_comb
  begin
    for (int k = 0; k < `IEB_NUM_REGS; k++)
    begin
      live_mask[k] = impl_mask(k[`IEB_IDX_W-1:0]) & variant_mask(k[`IEB_IDX_W-1:0]);
      for (int b = 0; b < `IEB_REG_W; b++)
      begin
        prio_nz[k][b] = (prio_q[k][b] != `IEB_PRIO_OFF); // [RULE14]
      end
    end
  end

  // read mux; priority words pack one field per nibble
  always_comb
  begin
    rdata_d = '0;
    unique case (dec.kind)
      DEC_EN: rdata_d[`IEB_REG_W-1:0] = en_q[dec.idx];
      DEC_FLAG: rdata_d[`IEB_REG_W-1:0] = flag_q[dec.idx];
      DEC_PRIO_LO, DEC_PRIO_HI:
      begin
        for (int n = 0; n < `IEB_HALF_FIELDS; n++)
        begin
          if (rd_impl[n + ((dec.kind == DEC_PRIO_HI) ? `IEB_HALF_FIELDS : 0)])
          begin
            rdata_d[n*`IEB_PRIO_NIB +: `IEB_PRIO_W] =
              prio_q[dec.idx][n + ((dec.kind == DEC_PRIO_HI) ? `IEB_HALF_FIELDS : 0)];
          end
        end
      end
      DEC_NONE: rdata_d = '0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= first_access;
    end
  end

  // read data and error captured with the wait state, held until next access
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else if (first_access)
    begin
      prdata_q <= PWRITE_I ? '0 : rdata_d;
      pslverr_q <= (dec.kind == DEC_NONE); // unmapped answers with an error
    end
  end

  // enable registers; unimplemented positions never store
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      en_q <= {`IEB_NUM_REGS{`IEB_EN_RESET}}; // [RULE3]
    end
    else if (wr_done && dec.kind == DEC_EN)
    begin
      en_q[dec.idx] <= merge16(en_q[dec.idx], PWDATA_I[`IEB_REG_W-1:0], PSTRB_I[1:0])
                       & impl_mask(dec.idx); // [RULE2] [RULE3]
    end
  end

  // flags: a request in the cycle of a software write still lands
  always_comb
  begin
    flag_d = flag_q;
    for (int k = 0; k < `IEB_NUM_REGS; k++)
    begin
      if (wr_done && dec.kind == DEC_FLAG && dec.idx == k[`IEB_IDX_W-1:0])
      begin
        flag_d[k] = merge16(flag_q[k], PWDATA_I[`IEB_REG_W-1:0], PSTRB_I[1:0]);
      end
      flag_d[k] = (flag_d[k] | SRC_REQ_I[k]) & impl_mask(k[`IEB_IDX_W-1:0]); // [RULE13]
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      flag_q <= {`IEB_NUM_REGS{`IEB_FLAG_RESET}};
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  // priority fields, one byte lane covers two fields
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      for (int k = 0; k < `IEB_NUM_REGS; k++)
      begin
        for (int b = 0; b < `IEB_REG_W; b++)
        begin
          prio_q[k][b] <= `IEB_PRIO_RESET;
        end
      end
    end
    else if (wr_done && (dec.kind == DEC_PRIO_LO || dec.kind == DEC_PRIO_HI))
    begin
      for (int n = 0; n < `IEB_HALF_FIELDS; n++)
      begin
        if (PSTRB_I[n/2])
        begin
          prio_q[dec.idx][n + ((dec.kind == DEC_PRIO_HI) ? `IEB_HALF_FIELDS : 0)] <=
            PWDATA_I[n*`IEB_PRIO_NIB +: `IEB_PRIO_W]; // [RULE14]
        end
      end
    end
  end

  // forwarded requests; registered so the dispatch sees clean levels
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      req_q <= '0;
    end
    else
    begin
      req_q <= flag_q & en_q & prio_nz & live_mask; // [RULE1] [RULE4] [RULE5] [RULE15]
    end
  end

  // outputs straight from flip-flops
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;
  assign IRQ_REQ_O = req_q;

  // ---- checks ----
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence

  sequence s_first_access;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence

  a_apb_one_wait: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    s_setup ##1 s_first_access |=> PREADY_O)
    else $error("pready did not rise after one wait state");

  a_req_needs_enable: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE1]
    (IRQ_REQ_O & ~$past(en_q)) == '0)
    else $error("request forwarded with its enable clear");

  a_unimpl_zero: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE2]
    ((en_q[0] & ~`IEB_IMPL0) | (en_q[1] & ~`IEB_IMPL1) | (en_q[2] & ~`IEB_IMPL2)
     | (en_q[3] & ~`IEB_IMPL3) | (en_q[4] & ~`IEB_IMPL4)) == '0)
    else $error("unimplemented enable bit holds a one");

  a_reset_clear: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE3]
    $rose(ARST_N_I) |-> (en_q == '0) && (IRQ_REQ_O == '0))
    else $error("enables not clear after reset");

  a_can_gated: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE4]
    !HAS_CAN |-> ((IRQ_REQ_O[2] & `IEB_CAN_BITS2) | (IRQ_REQ_O[4] & `IEB_CAN_BITS4)) == '0)
    else $error("CAN request forwarded on a variant without it");

  a_dac_gated: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE5]
    !HAS_DAC |-> (IRQ_REQ_O[4] & `IEB_DAC_BITS4) == '0)
    else $error("converter request forwarded on a variant without it");

  a_en0_write: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE6]
    (wr_done && dec.kind == DEC_EN && dec.idx == 3'h0 && PSTRB_I[1:0] == 2'h3)
    |=> en_q[0] == ($past(PWDATA_I[`IEB_REG_W-1:0]) & `IEB_IMPL0))
    else $error("first enable register write mismatch");

  a_en1_write: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE7]
    (wr_done && dec.kind == DEC_EN && dec.idx == 3'h1 && PSTRB_I[1:0] == 2'h3)
    |=> en_q[1] == ($past(PWDATA_I[`IEB_REG_W-1:0]) & `IEB_IMPL1))
    else $error("second enable register write mismatch");

  a_flag_set_wins: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE13]
    SRC_REQ_I[1][0] |=> flag_q[1][0])
    else $error("source request lost from its flag");

  a_prio_zero_blocks: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE14]
    (prio_q[1][0] == `IEB_PRIO_OFF) |=> !IRQ_REQ_O[1][0])
    else $error("zero priority source forwarded");

  a_req_latency: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I) // [RULE15]
    (flag_q[0][1] && en_q[0][1] && prio_nz[0][1]) |=> IRQ_REQ_O[0][1])
    else $error("qualified request not forwarded next cycle");

endmodule

`default_nettype wire

// >>> rtl/irq_enable_defines.svh
/*
  Constants of the interrupt enable bank: sizes, register offsets, field
  positions, reset values and the masks of implemented bits.
  Assumes it is included by its bare name; holds definitions only.
*/
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

// bank geometry
`define IEB_NUM_REGS 5
`define IEB_REG_W 16
`define IEB_IDX_W 3
`define IEB_PRIO_W 3
`define IEB_PRIO_NIB 4
`define IEB_HALF_FIELDS 8
`define IEB_ADDR_W 8
`define IEB_DATA_W 32

// byte offsets on the register bus
`define IEB_EN_BASE 8'h00
`define IEB_EN_LAST 8'h10
`define IEB_FLAG_BASE 8'h20
`define IEB_FLAG_LAST 8'h30
`define IEB_PRIO_BASE 8'h40
`define IEB_PRIO_LAST 8'h64

// reset values and the priority value that disables a source
`define IEB_EN_RESET 16'h0000
`define IEB_FLAG_RESET 16'h0000
`define IEB_PRIO_RESET 3'h4
`define IEB_PRIO_OFF 3'h0

// implemented bit positions of each enable register
`define IEB_IMPL0 16'h0007
`define IEB_IMPL1 16'hffdf
`define IEB_IMPL2 16'h601f
`define IEB_IMPL3 16'he600
`define IEB_IMPL4 16'hce7e

// variant-dependent bits
`define IEB_CAN_BITS2 16'h000c
`define IEB_CAN_BITS4 16'h0040
`define IEB_DAC_BITS4 16'hc000

`endif

// >>> rtl/irq_enable_pkg.sv
/*
  Types shared by the interrupt enable bank.
  Assumes irq_enable_defines.svh is on the include path.
*/
`include "irq_enable_defines.svh"

package irq_enable_pkg;

  typedef logic [`IEB_REG_W-1:0] word_t;
  typedef logic [`IEB_NUM_REGS-1:0][`IEB_REG_W-1:0] irq_bank_t;
  typedef logic [`IEB_PRIO_W-1:0] prio_t;

  // what an address selects
  typedef enum logic [2:0] {DEC_NONE, DEC_EN, DEC_FLAG, DEC_PRIO_LO, DEC_PRIO_HI} dec_kind_t;

  typedef struct packed {
    dec_kind_t kind;
    logic [`IEB_IDX_W-1:0] idx;
  } dec_t;

endpackage

// >>> tb/dispatch_model.sv
/*
  Far-side model: the processor dispatch takes each forwarded request level.
  Assumes the bank's clock and active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module dispatch_model
  import irq_enable_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire irq_bank_t req_i,
  output var irq_bank_t pending_o
);
  // pending follows the request one cycle later, as a registered sampler would
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pending_o <= '0;
    else
      pending_o <= req_i;
  end
endmodule

`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench: APB driver with an expectation queue, read monitor,
  request stimulus and a second bank built without the optional peripherals.
  Assumes the bank answers each transfer with one wait state.
*/
`timescale 1ns/1ns
`default_nettype none

`include "irq_enable_defines.svh"

module tb
  import irq_enable_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  irq_bank_t src = '0;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  irq_bank_t irq;
  irq_bank_t irq_lite;
  irq_bank_t pend;
  irq_bank_t exp_irq;
  irq_bank_t var_m;
  word_t impl [5] = '{`IEB_IMPL0, `IEB_IMPL1, `IEB_IMPL2, `IEB_IMPL3, `IEB_IMPL4};
  logic [32:0] exp_q [$];
  logic [31:0] seed = 32'hea8aebec;
  logic [31:0] d;
  int k;
  int err_count = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  interrupt_enable_bank dut_u (.REF_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .SRC_REQ_I(src),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .IRQ_REQ_O(irq));

  // same bus, no can or converter: shows the variant masking only
  interrupt_enable_bank #(.HAS_CAN(1'b0), .HAS_DAC(1'b0)) dut_lite_u (.REF_CLK_I(clk), .ARST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'hf), .SRC_REQ_I(src), .PRDATA_O(), .PREADY_O(), .PSLVERR_O(), .IRQ_REQ_O(irq_lite));

  dispatch_model disp_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(irq), .pending_o(pend));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one transfer; e is {slave error, read data}, noted at setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [32:0] e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= dat;
    exp_q.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_count++;
      end_of_test();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // completion monitor: values read here are those sampled at the edge
  always @(posedge clk)
  begin
    if (psel && pen && pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("apb_extra", 80'h1, 80'h0);
      else
        check("apb", {47'h0, perr, prdata}, {47'h0, exp_q.pop_front()});
    end
  end

  // masking lags the qualifying change by a fixed two edges, three is safe
  task automatic cmp_irq();
    repeat (3) @(posedge clk);
    check("irq", irq, exp_irq);
    check("irq_lite", irq_lite, exp_irq & ~var_m);
    check("pending", pend, exp_irq);
  endtask

  initial
  begin
    var_m = '0;
    var_m[2] = `IEB_CAN_BITS2;
    var_m[4] = `IEB_CAN_BITS4 | `IEB_DAC_BITS4;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 5; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0, 33'h0);
      apb(1'b0, 8'(8'h20 + 4 * k), 32'h0, 33'h0);
      apb(1'b1, 8'(4 * k), 32'hffff_ffff, 33'h0);
      apb(1'b0, 8'(4 * k), 32'h0, {17'h0, impl[k]});
    end
    // random patterns catch bits stuck in one state
    repeat (8)
    begin
      k = int'(xs() % 32'd5);
      d = xs();
      apb(1'b1, 8'(4 * k), d, 33'h0);
      apb(1'b0, 8'(4 * k), 32'h0, {17'h0, d[15:0] & impl[k]});
    end
    apb(1'b1, 8'h14, 32'hffff, {1'b1, 32'h0});
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 8'h80, 32'h0, {1'b1, 32'h0});
    for (k = 0; k < 5; k++)
      apb(1'b1, 8'(4 * k), 32'hffff, 33'h0);
    @(posedge clk);
    src <= '1;
    @(posedge clk);
    src <= '0;
    for (k = 0; k < 5; k++)
      exp_irq[k] = impl[k];
    cmp_irq();
    for (k = 0; k < 5; k++)
      apb(1'b0, 8'(8'h20 + 4 * k), 32'h0, {17'h0, impl[k]});
    apb(1'b1, 8'h00, 32'h0, 33'h0);
    exp_irq[0] = 16'h0;
    cmp_irq();
    apb(1'b1, 8'h48, 32'h0, 33'h0);
    apb(1'b0, 8'h48, 32'h0, 33'h0);
    apb(1'b0, 8'h4c, 32'h0, {1'b0, {8{1'b0, `IEB_PRIO_RESET}}});
    apb(1'b0, 8'h40, 32'h0, {21'h0, {3{1'b0, `IEB_PRIO_RESET}}});
    exp_irq[1][7:0] = 8'h00;
    cmp_irq();
    for (k = 0; k < 5; k++)
      apb(1'b1, 8'(8'h20 + 4 * k), 32'h0, 33'h0);
    exp_irq = '0;
    cmp_irq();
    end_of_test();
  end
endmodule

`default_nettype wire
